// ==== design/bcg_pkg.sv ====
// Purpose: Constants for the breaker configuration store and command gate
// Assumes: One 40 MHz clock, settings written one field at a time
// Notes: Factory defaults load on reset and on an initialise strobe
// Notes on behaviour
// (RL1) Address writes are accepted only from 1 to 224.
// (RL2) Factory default network address is 222.
// (RL3) Installers should use addresses 1 to 221, keeping 222 for parking.
// (RL4) Every unit on one network needs its own unique address.
// (RL5) Link rate choices are 2400, 4800 and 9600 baud only.
// (RL6) Factory default link rate is 4800 baud.
// (RL7) All units and the master share one link rate.
// (RL8) Phase current scale holds 80 to 4000 and scales currents and power.
// (RL9) Phase sequence is normal or inverted; steers voltage and power maths.
// (RL10) Feed direction sets power sign and energy count direction.
// (RL11) Three-wire mode hides phase-neutral voltages; four-wire shows them.
// (RL12) Nominal voltage scale feeds only the unbalance alarm and relay.
// (RL13) Demand subperiod length is 1 to 99 minutes, count 1 to 15.
// (RL14) Demand window is length times count; count one means fixed interval.
// (RL15) Remote trip sequence is executed only while trip permit is on.
// (RL16) Trip permit never touches the protective trip functions.
// (RL17) Remote close is recognised and drives close output only with permit.
// (RL18) Remote open is recognised and drives open output only with permit.
// (RL19) Each remote trip, close or open writes an event log entry.
// (RL20) With open permit on, only remote open drives the output contact.
// (RL21) Remote open activates the contact until breaker-open input asserts.
// (RL22) With open permit off, alarms drive the contact with no auto release.
// (RL23) Reads are free; configuration writes need a valid password first.
// (RL24) Out-of-range writes are rejected and the old value is kept.
// (RL25) Initialisation loads factory defaults with all remote permits off.
package bcg_pkg;
	// Field selectors for the configuration write port
	localparam logic [3:0] SEL_ADDR = 4'h0;
	localparam logic [3:0] SEL_BAUD = 4'h1;
	localparam logic [3:0] SEL_ISCALE = 4'h2;
	localparam logic [3:0] SEL_ROT = 4'h3;
	localparam logic [3:0] SEL_SRC = 4'h4;
	localparam logic [3:0] SEL_VSCALE = 4'h5;
	localparam logic [3:0] SEL_VMODE = 4'h6;
	localparam logic [3:0] SEL_DLEN = 4'h7;
	localparam logic [3:0] SEL_DCNT = 4'h8;
	localparam logic [3:0] SEL_PTRIP = 4'h9;
	localparam logic [3:0] SEL_PCLOSE = 4'hA;
	localparam logic [3:0] SEL_POPEN = 4'hB;
	// Ranges and defaults
	localparam logic [15:0] ADDR_MIN = 16'h0001;
	localparam logic [15:0] ADDR_MAX = 16'h00E0;
	localparam logic [7:0] ADDR_DEF = 8'hDE;
	localparam logic [15:0] BAUD_2400 = 16'h0960;
	localparam logic [15:0] BAUD_4800 = 16'h12C0;
	localparam logic [15:0] BAUD_9600 = 16'h2580;
	localparam logic [1:0] BCODE_2400 = 2'h0;
	localparam logic [1:0] BCODE_4800 = 2'h1;
	localparam logic [1:0] BCODE_9600 = 2'h2;
	localparam logic [15:0] ISC_MIN = 16'h0050;
	localparam logic [15:0] ISC_MAX = 16'h0FA0;
	localparam logic [11:0] ISC_DEF = 12'h096;
	localparam logic [15:0] VSC_MIN = 16'h0001;
	localparam logic [15:0] VSC_MAX = 16'h0FFF;
	localparam logic [11:0] VSC_DEF = 12'h258;
	localparam logic [15:0] DLEN_MIN = 16'h0001;
	localparam logic [15:0] DLEN_MAX = 16'h0063;
	localparam logic [6:0] DLEN_DEF = 7'h01;
	localparam logic [15:0] DCNT_MIN = 16'h0001;
	localparam logic [15:0] DCNT_MAX = 16'h000F;
	localparam logic [3:0] DCNT_DEF = 4'hF;
	localparam logic [15:0] BOOL_MAX = 16'h0001;
	// Command codes from the link decoder
	localparam logic [1:0] CMD_TRIP = 2'h1;
	localparam logic [1:0] CMD_CLOSE = 2'h2;
	localparam logic [1:0] CMD_OPEN = 2'h3;
	// Event codes towards the event log
	localparam logic [1:0] EV_TRIP = 2'h1;
	localparam logic [1:0] EV_CLOSE = 2'h2;
	localparam logic [1:0] EV_OPEN = 2'h3;
	// Open contact state machine
	typedef enum logic [1:0] {
		BCG_IDLE = 2'b01,
		BCG_HOLD = 2'b10
	} bcg_open_e;
endpackage : bcg_pkg

// ==== design/bcg_gate.sv ====
// Purpose: Configuration store and remote command gate for a trip unit
// Assumes: Commands arrive decoded as one-cycle strobes on clk_in
// Notes: Breaker-open and alarm levels come from pins and are synchronised
`timescale 1ns/1ps
`default_nettype none
module bcg_gate (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic init_in,
	input wire logic pwd_ok_in,
	input wire logic wr_in,
	input wire logic [3:0] wr_sel_in,
	input wire logic [15:0] wr_data_in,
	input wire logic cmd_in,
	input wire logic [1:0] cmd_code_in,
	input wire logic breaker_open_aux_input_in,
	input wire logic alarm_req_in,
	output logic wr_ack_out,
	output logic wr_rej_out,
	output logic [7:0] addr_out,
	output logic [1:0] baud_out,
	output logic [11:0] iscale_out,
	output logic rot_inv_out,
	output logic src_bottom_out,
	output logic [11:0] vscale_out,
	output logic ln_volt_en_out,
	output logic [6:0] dlen_out,
	output logic [3:0] dcnt_out,
	output logic [10:0] dwin_out,
	output logic dfixed_out,
	output logic ptrip_out,
	output logic pclose_out,
	output logic popen_out,
	output logic trip_out,
	output logic close_out,
	output logic open_alarm_out,
	output logic ev_out,
	output logic [1:0] ev_code_out
);
	import bcg_pkg::*;

	logic [7:0] addr_ff;
	logic [1:0] baud_ff;
	logic [11:0] isc_ff;
	logic rot_ff;
	logic src_ff;
	logic [11:0] vsc_ff;
	logic vmode4_ff;
	logic [6:0] dlen_ff;
	logic [3:0] dcnt_ff;
	logic ptrip_ff;
	logic pclose_ff;
	logic popen_ff;
	logic ack_ff;
	logic rej_ff;
	logic trip_ff;
	logic close_ff;
	logic oa_ff;
	logic ev_ff;
	logic [1:0] evc_ff;
	logic ln_ff;
	logic [10:0] dwin_ff;
	logic dfix_ff;
	logic brk_s1_ff;
	logic brk_s2_ff;
	logic alm_s1_ff;
	logic alm_s2_ff;
	bcg_open_e st_ff;
	bcg_open_e nxt_st;

	// Range checks per field
	wire in_addr = (wr_data_in >= ADDR_MIN) && (wr_data_in <= ADDR_MAX);
	wire is_b24 = wr_data_in == BAUD_2400;
	wire is_b48 = wr_data_in == BAUD_4800;
	wire is_b96 = wr_data_in == BAUD_9600;
	wire in_baud = is_b24 || is_b48 || is_b96;
	wire in_isc = (wr_data_in >= ISC_MIN) && (wr_data_in <= ISC_MAX);
	wire in_vsc = (wr_data_in >= VSC_MIN) && (wr_data_in <= VSC_MAX);
	wire in_dlen = (wr_data_in >= DLEN_MIN) && (wr_data_in <= DLEN_MAX);
	wire in_dcnt = (wr_data_in >= DCNT_MIN) && (wr_data_in <= DCNT_MAX);
	wire in_bool = wr_data_in <= BOOL_MAX;
	wire [1:0] baud_code = is_b24 ? BCODE_2400 :
		(is_b48 ? BCODE_4800 : BCODE_9600);
	wire sel_bool = (wr_sel_in == SEL_ROT) || (wr_sel_in == SEL_SRC) ||
		(wr_sel_in == SEL_VMODE) || (wr_sel_in == SEL_PTRIP) ||
		(wr_sel_in == SEL_PCLOSE) || (wr_sel_in == SEL_POPEN);
	wire val_ok = (wr_sel_in == SEL_ADDR) ? in_addr :
		(wr_sel_in == SEL_BAUD) ? in_baud :
		(wr_sel_in == SEL_ISCALE) ? in_isc :
		(wr_sel_in == SEL_VSCALE) ? in_vsc :
		(wr_sel_in == SEL_DLEN) ? in_dlen :
		(wr_sel_in == SEL_DCNT) ? in_dcnt :
		(sel_bool && in_bool);
	// (RL23) password gated writes
	wire wr_go = wr_in && pwd_ok_in && !init_in;
	// (RL24) only in-range values stored
	wire wr_take = wr_go && val_ok;
	wire b0 = wr_data_in[0];

	// Remote command recognition, each behind its own permit
	// (RL15) trip needs permit
	wire do_trip = cmd_in && (cmd_code_in == CMD_TRIP) && ptrip_ff;
	// (RL17) close needs permit
	wire do_close = cmd_in && (cmd_code_in == CMD_CLOSE) && pclose_ff;
	// (RL18) open needs permit
	wire do_open = cmd_in && (cmd_code_in == CMD_OPEN) && popen_ff;
	wire do_any = do_trip || do_close || do_open;
	wire [1:0] ev_code = do_trip ? EV_TRIP : (do_close ? EV_CLOSE : EV_OPEN);

	// Open contact ownership: held state ends when the breaker is seen open
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			BCG_IDLE: begin
				if (do_open && !brk_s2_ff)
					nxt_st = BCG_HOLD;
			end
			BCG_HOLD: begin
				// (RL21) release on breaker open
				if (brk_s2_ff || !popen_ff)
					nxt_st = BCG_IDLE;
			end
			default: nxt_st = BCG_IDLE;
		endcase
	end
	// (RL20) permit owns the contact
	// (RL22) alarms own it otherwise
	wire nxt_oa = popen_ff ? (nxt_st == BCG_HOLD) : alm_s2_ff;
	// (RL11) line-neutral voltages in four-wire only
	wire nxt_ln = vmode4_ff;
	// (RL14) demand window is length times count
	wire [10:0] nxt_dwin = 11'(dlen_ff * dcnt_ff);
	wire nxt_dfix = dcnt_ff == DCNT_MIN[3:0];

	// Pin synchronisers; first stage feeds only the second
	always_ff @(posedge clk_in) begin
		brk_s1_ff <= breaker_open_aux_input_in;
		brk_s2_ff <= brk_s1_ff;
		alm_s1_ff <= alarm_req_in;
		alm_s2_ff <= alm_s1_ff;
	end

	// Settings store; init has priority over writes
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || init_in) begin
			// (RL25) factory defaults
			// (RL2) address default
			addr_ff <= ADDR_DEF;
			// (RL6) baud default
			baud_ff <= BCODE_4800;
			isc_ff <= ISC_DEF;
			rot_ff <= 1'b0;
			src_ff <= 1'b0;
			vsc_ff <= VSC_DEF;
			vmode4_ff <= 1'b0;
			dlen_ff <= DLEN_DEF;
			dcnt_ff <= DCNT_DEF;
			ptrip_ff <= 1'b0;
			pclose_ff <= 1'b0;
			popen_ff <= 1'b0;
		end else if (wr_take) begin
			case (wr_sel_in)
				// (RL1) address range
				SEL_ADDR: addr_ff <= wr_data_in[7:0];
				// (RL5) three baud choices
				SEL_BAUD: baud_ff <= baud_code;
				// (RL8) phase scale range
				SEL_ISCALE: isc_ff <= wr_data_in[11:0];
				// (RL9) phase sequence
				SEL_ROT: rot_ff <= b0;
				// (RL10) feed direction
				SEL_SRC: src_ff <= b0;
				// (RL12) unbalance scale only
				SEL_VSCALE: vsc_ff <= wr_data_in[11:0];
				SEL_VMODE: vmode4_ff <= b0;
				// (RL13) demand ranges
				SEL_DLEN: dlen_ff <= wr_data_in[6:0];
				SEL_DCNT: dcnt_ff <= wr_data_in[3:0];
				SEL_PTRIP: ptrip_ff <= b0;
				SEL_PCLOSE: pclose_ff <= b0;
				SEL_POPEN: popen_ff <= b0;
				default: addr_ff <= addr_ff;
			endcase
		end
	end

	// Command outputs, event pulses and derived views
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st_ff <= BCG_IDLE;
			ack_ff <= 1'b0;
			rej_ff <= 1'b0;
			trip_ff <= 1'b0;
			close_ff <= 1'b0;
			oa_ff <= 1'b0;
			ev_ff <= 1'b0;
			evc_ff <= 2'h0;
			ln_ff <= 1'b0;
			dwin_ff <= 11'(DLEN_DEF * DCNT_DEF);
			dfix_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			ack_ff <= wr_take;
			rej_ff <= wr_go && !val_ok;
			trip_ff <= do_trip;
			close_ff <= do_close;
			oa_ff <= nxt_oa;
			// (RL19) log every remote action
			ev_ff <= do_any;
			evc_ff <= do_any ? ev_code : 2'h0;
			ln_ff <= nxt_ln;
			dwin_ff <= nxt_dwin;
			dfix_ff <= nxt_dfix;
		end
	end

	assign wr_ack_out = ack_ff;
	assign wr_rej_out = rej_ff;
	assign addr_out = addr_ff;
	assign baud_out = baud_ff;
	assign iscale_out = isc_ff;
	assign rot_inv_out = rot_ff;
	assign src_bottom_out = src_ff;
	assign vscale_out = vsc_ff;
	assign ln_volt_en_out = ln_ff;
	assign dlen_out = dlen_ff;
	assign dcnt_out = dcnt_ff;
	assign dwin_out = dwin_ff;
	assign dfixed_out = dfix_ff;
	// (RL16) trip permit has no path to protection; it gates only trip_out and the trip event
	assign ptrip_out = ptrip_ff;
	assign pclose_out = pclose_ff;
	assign popen_out = popen_ff;
	assign trip_out = trip_ff;
	assign close_out = close_ff;
	assign open_alarm_out = oa_ff;
	assign ev_out = ev_ff;
	assign ev_code_out = evc_ff;

	// Checks; the edge after a reset is skipped where history matters
	property p_addr_rng;
		@(posedge clk_in) disable iff (!rst_n_in)
		(addr_ff >= ADDR_MIN[7:0]) && ({8'h00, addr_ff} <= ADDR_MAX);
	endproperty
	a_addr_rng: assert property (p_addr_rng) // RL1
		else $error("address out of range");
	property p_reject;
		@(posedge clk_in) disable iff (!rst_n_in)
		(wr_go && !val_ok && (wr_sel_in == SEL_ADDR)) |=>
			$stable(addr_ff) && rej_ff;
	endproperty
	a_reject: assert property (p_reject) // RL24
		else $error("bad write stored");
	property p_init;
		@(posedge clk_in) disable iff (!rst_n_in)
		init_in |=> (addr_ff == ADDR_DEF) && (baud_ff == BCODE_4800) && !popen_ff;
	endproperty
	a_init: assert property (p_init) // RL25
		else $error("defaults not loaded");
	property p_trip;
		@(posedge clk_in) disable iff (!rst_n_in)
		trip_ff |-> $past(ptrip_ff) && $past(cmd_in);
	endproperty
	a_trip: assert property (p_trip) // RL15
		else $error("trip without permit");
	property p_close;
		@(posedge clk_in) disable iff (!rst_n_in)
		close_ff |-> $past(pclose_ff);
	endproperty
	a_close: assert property (p_close) // RL17
		else $error("close without permit");
	property p_event;
		@(posedge clk_in) disable iff (!rst_n_in)
		(trip_ff || close_ff) |-> ev_ff;
	endproperty
	a_event: assert property (p_event) // RL19
		else $error("remote action not logged");
	property p_owner;
		@(posedge clk_in) disable iff (!rst_n_in)
		(!popen_ff && $past(!popen_ff) && $past(rst_n_in)) |->
			(oa_ff == $past(alm_s2_ff));
	endproperty
	a_owner: assert property (p_owner) // RL22
		else $error("alarm lost contact");
	property p_release;
		@(posedge clk_in) disable iff (!rst_n_in)
		(st_ff == BCG_HOLD && brk_s2_ff && popen_ff) |=> !oa_ff;
	endproperty
	a_release: assert property (p_release) // RL21
		else $error("contact not released");
	// Holding the contact is only ever entered by a permitted open
	property p_open_gate;
		@(posedge clk_in) disable iff (!rst_n_in)
		$rose(st_ff == BCG_HOLD) |->
			$past(cmd_in && (cmd_code_in == CMD_OPEN) && popen_ff);
	endproperty
	a_open_gate: assert property (p_open_gate) // RL18
		else $error("open held without permit");
	property p_owner_open;
		@(posedge clk_in) disable iff (!rst_n_in)
		(popen_ff && $past(popen_ff)) |-> (oa_ff == (st_ff == BCG_HOLD));
	endproperty
	a_owner_open: assert property (p_owner_open) // RL20
		else $error("alarm reached owned contact");
	property p_ln_mode;
		@(posedge clk_in) disable iff (!rst_n_in)
		$past(rst_n_in) |-> (ln_ff == $past(vmode4_ff));
	endproperty
	a_ln_mode: assert property (p_ln_mode) // RL11
		else $error("line-neutral enable wrong");
	property p_dwin;
		@(posedge clk_in) disable iff (!rst_n_in)
		$past(rst_n_in) |->
			(dwin_ff == 11'($past(dlen_ff) * $past(dcnt_ff))) &&
			(dfix_ff == ($past(dcnt_ff) == DCNT_MIN[3:0]));
	endproperty
	a_dwin: assert property (p_dwin) // RL14
		else $error("demand window wrong");
	property p_trip_src;
		@(posedge clk_in) disable iff (!rst_n_in)
		trip_ff |-> $past(cmd_code_in == CMD_TRIP);
	endproperty
	a_trip_src: assert property (p_trip_src) // RL16
		else $error("trip from a non-trip source");
	property p_dem_rng;
		@(posedge clk_in) disable iff (!rst_n_in)
		(dlen_ff >= DLEN_MIN[6:0]) && (dlen_ff <= DLEN_MAX[6:0]) &&
			(dcnt_ff >= DCNT_MIN[3:0]);
	endproperty
	a_dem_rng: assert property (p_dem_rng) // RL13
		else $error("demand setting out of range");
endmodule : bcg_gate
`default_nettype wire

// ==== verif/bcg_master.sv ====
// Purpose: Master device model driving settings writes and commands
// Assumes: Requests change just after a rising edge of clk_in
// Notes: Released data and code lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module bcg_master (
	input wire logic clk_in,
	output logic pwd_ok_out,
	output logic wr_out,
	output logic [3:0] sel_out,
	output logic [15:0] data_out,
	output logic cmd_out,
	output logic [1:0] code_out
);
	localparam int LINK_BAUD = 4800;
	// Idle state; password held valid unless a write says otherwise
	initial begin
		pwd_ok_out = 1'b1;
		wr_out = 1'b0;
		sel_out = 4'h0;
		data_out = 16'h0000;
		cmd_out = 1'b0;
		code_out = 2'h0;
	end
	// One write: held over the taking edge, then released inverted
	task automatic wr_field(input logic [3:0] s, input logic [15:0] d,
		input logic p);
		@(posedge clk_in);
		wr_out <= 1'b1;
		sel_out <= s;
		data_out <= d;
		pwd_ok_out <= p;
		@(posedge clk_in);
		wr_out <= 1'b0;
		data_out <= ~d;
		pwd_ok_out <= 1'b1;
		#1;
	endtask : wr_field
	// One command strobe, same holding discipline
	task automatic send(input logic [1:0] c);
		@(posedge clk_in);
		cmd_out <= 1'b1;
		code_out <= c;
		@(posedge clk_in);
		cmd_out <= 1'b0;
		code_out <= ~c;
		#1;
	endtask : send
endmodule : bcg_master
`default_nettype wire

// ==== verif/tb_breaker_config_command_gate.sv ====
// Purpose: Self-checking bench for the configuration store and gate
// Assumes: Design answers one cycle after each taken request
// Notes: Breaker and alarm pins pass a 2-FF sync, so waits are bounded
`timescale 1ns/1ps
`default_nettype none
module tb_breaker_config_command_gate;
	import bcg_pkg::*;
	logic clk_in, rst_n_in, init_in, pwd_ok, wr, cmd, brk, alarm;
	logic [3:0] sel;
	logic [15:0] data;
	logic [1:0] code;
	logic ack, rej, rot, src, lnv, dfix, pt, pc, po, trip, cls, oa, ev;
	logic [7:0] addr;
	logic [1:0] baud, evc;
	logic [11:0] isc, vsc;
	logic [6:0] dlen;
	logic [3:0] dcnt;
	logic [10:0] dwin;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	bcg_master i_master (.clk_in(clk_in), .pwd_ok_out(pwd_ok), .wr_out(wr),
		.sel_out(sel), .data_out(data), .cmd_out(cmd), .code_out(code));
	bcg_gate i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .init_in(init_in),
		.pwd_ok_in(pwd_ok), .wr_in(wr), .wr_sel_in(sel), .wr_data_in(data),
		.cmd_in(cmd), .cmd_code_in(code), .breaker_open_aux_input_in(brk),
		.alarm_req_in(alarm), .wr_ack_out(ack), .wr_rej_out(rej),
		.addr_out(addr), .baud_out(baud), .iscale_out(isc), .rot_inv_out(rot),
		.src_bottom_out(src), .vscale_out(vsc), .ln_volt_en_out(lnv),
		.dlen_out(dlen), .dcnt_out(dcnt), .dwin_out(dwin),
		.dfixed_out(dfix), .ptrip_out(pt), .pclose_out(pc), .popen_out(po),
		.trip_out(trip), .close_out(cls), .open_alarm_out(oa), .ev_out(ev),
		.ev_code_out(evc));
	// Free-running 40 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	// Verdict and end of run, reached from the sequence or the timeout
	task automatic results;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Write and check the accept/reject pair {ack, rej}
	task automatic wt(input logic [3:0] s, input logic [15:0] d,
		input logic [1:0] e, input logic p = 1'b1);
		i_master.wr_field(s, d, p);
		chk(16'({ack, rej}), 16'(e));
	endtask : wt
	// Command and check {trip, close, event, event code}
	task automatic cm(input logic [1:0] c, input logic [4:0] e);
		i_master.send(c);
		chk(16'({trip, cls, ev, evc}), 16'(e));
	endtask : cm
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : wait_n
	// Hang guard, far above the roughly 90 cycles the run needs
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			results();
		end
	end
	initial begin
		rst_n_in = 1'b0;
		init_in = 1'b0;
		brk = 1'b0;
		alarm = 1'b0;
		wait_n(3);
		rst_n_in <= 1'b1;
		#1;
		chk(16'(addr), 16'h00DE);
		chk(16'(baud), 16'h0001);
		chk(16'({isc, dcnt}), 16'h096F);
		chk(16'({dlen, dwin}), 16'h080F);
		chk(16'({pt, pc, po, oa, lnv, dfix}), 16'h0000);
		$display("test defaults done");
		wt(SEL_ADDR, 16'h0000, 2'b01);
		wt(SEL_ADDR, 16'h00E1, 2'b01);
		chk(16'(addr), 16'h00DE);
		wt(SEL_ADDR, 16'h00E0, 2'b10);
		wt(SEL_ADDR, 16'h00DD, 2'b10);
		wt(SEL_ADDR, 16'h0005, 2'b00, 1'b0);
		chk(16'(addr), 16'h00DD);
		wt(SEL_BAUD, 16'h0960, 2'b10);
		wt(SEL_BAUD, 16'h04B0, 2'b01);
		chk(16'(baud), 16'h0000);
		wt(SEL_BAUD, 16'h2580, 2'b10);
		chk(16'(baud), 16'h0002);
		wt(SEL_ISCALE, 16'h004F, 2'b01);
		wt(SEL_ISCALE, 16'h0FA1, 2'b01);
		wt(SEL_ISCALE, 16'h0050, 2'b10);
		chk(16'(isc), 16'h0050);
		wt(SEL_ROT, 16'h0002, 2'b01);
		wt(SEL_ROT, 16'h0001, 2'b10);
		wt(SEL_SRC, 16'h0001, 2'b10);
		wt(SEL_VMODE, 16'h0001, 2'b10);
		wt(SEL_VSCALE, 16'h01E0, 2'b10);
		chk(16'({rot, src, lnv, vsc}), 16'h71E0);
		wt(SEL_DLEN, 16'h0064, 2'b01);
		wt(SEL_DCNT, 16'h0010, 2'b01);
		wt(SEL_DLEN, 16'h0063, 2'b10);
		wt(4'hC, 16'h0000, 2'b01);
		chk(16'({dfix, dwin}), 16'h05CD);
		wt(SEL_DCNT, 16'h0001, 2'b10);
		wt(SEL_DCNT, 16'h0000, 2'b01);
		chk(16'({dfix, dwin}), 16'h0863);
		wt(SEL_BAUD, 16'(i_master.LINK_BAUD), 2'b10);
		chk(16'(baud), 16'(BCODE_4800));
		$display("test settings done");
		cm(CMD_TRIP, 5'b00000);
		cm(CMD_CLOSE, 5'b00000);
		cm(CMD_OPEN, 5'b00000);
		wt(SEL_PTRIP, 16'h0001, 2'b10);
		wt(SEL_PCLOSE, 16'h0001, 2'b10);
		wt(SEL_POPEN, 16'h0001, 2'b10);
		alarm <= 1'b1;
		wait_n(5);
		chk(16'({pt, pc, po, oa}), 16'h000E);
		cm(CMD_TRIP, 5'b10101);
		cm(CMD_CLOSE, 5'b01110);
		cm(CMD_OPEN, 5'b00111);
		chk(16'(oa), 16'h0001);
		brk <= 1'b1;
		wait_n(1);
		chk(16'(oa), 16'h0001);
		wait_n(4);
		chk(16'(oa), 16'h0000);
		wt(SEL_POPEN, 16'h0000, 2'b10);
		wait_n(5);
		chk(16'(oa), 16'h0001);
		alarm <= 1'b0;
		wait_n(5);
		chk(16'(oa), 16'h0000);
		$display("test commands done");
		init_in <= 1'b1;
		wait_n(1);
		init_in <= 1'b0;
		chk(16'({addr, pt, pc, po, baud}), 16'h1BC1);
		$display("test init done");
		results();
	end
endmodule : tb_breaker_config_command_gate
`default_nettype wire
